// File: src/bsd_pkg.sv
// Function
// - Sample/preload code captures pin states and preloads the boundary pattern.
// - External-test code drives boundary contents on pins and captures inputs.
// - All-ones code puts the one-bit bypass register between TDI and TDO.
// - User-code instruction shifts the 32-bit user-code register out on TDO.
// - Identification instruction shifts the identification register out on TDO.
// - High-impedance code selects bypass and tri-states every I/O pin.
// - Clamp code selects bypass and holds pins at boundary register levels.
// - Emulated reconfig pulse triggers reconfiguration like config_request_n low.
// - I/O-standard programming code is accepted before, during or after configuration.
// - I/O-standard programming issued during configuration aborts that configuration.
// - After I/O-standard programming, config_status_n stays low until reconfigured.
// - The scan chain may update every pin's I/O standard anytime.
// - Before configuration the PLL reconfiguration bits sit inside the scan chain.
// - After configuration the PLL bits leave the chain, shortening it.
// - The instruction register is ten bits; the tester shifts exactly ten.
// - Identification is version, part number, maker, then a one in the LSB.
// - Enabled bus-hold overrides high impedance under high-Z, clamp and external test.
package bsd_pkg;

    localparam int IR_LEN   = 10;
    localparam int ID_LEN   = 32;
    localparam int PINS     = 4;
    localparam int CELLS    = 3;
    localparam int BSR_LEN  = PINS * CELLS;
    localparam int PLL_BITS = 4;
    localparam int IOSTD_W  = 2;
    localparam int IOSTD_LEN = PINS * IOSTD_W;

    // Boundary cell order within one pin: captured input, output data, output enable.
    localparam int CELL_IN  = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE  = 2;

    localparam logic [IR_LEN-1:0] IR_EXTEST    = 10'h000;
    localparam logic [IR_LEN-1:0] IR_RECONFIG  = 10'h001;
    localparam logic [IR_LEN-1:0] IR_SAMPLE    = 10'h005;
    localparam logic [IR_LEN-1:0] IR_IDCODE    = 10'h006;
    localparam logic [IR_LEN-1:0] IR_USERCODE  = 10'h007;
    localparam logic [IR_LEN-1:0] IR_CLAMP     = 10'h00A;
    localparam logic [IR_LEN-1:0] IR_HIGHZ     = 10'h00B;
    localparam logic [IR_LEN-1:0] IR_CONFIG_IO = 10'h00D;
    localparam logic [IR_LEN-1:0] IR_BYPASS    = 10'h3FF;
    localparam logic [IR_LEN-1:0] IR_CAPTURE   = 10'h001;

    // Identification fields; the values are arbitrary.
    localparam logic [3:0]  ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART    = 16'h5A3C;
    localparam logic [10:0] ID_MAKER   = 11'h02B;
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    localparam logic [ID_LEN-1:0] USERCODE_VALUE = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } bsd_tap_e;

    typedef enum logic [2:0] {DR_BYPASS, DR_IDCODE, DR_USERCODE, DR_BOUNDARY, DR_IOSTD} bsd_dr_e;

    typedef enum logic [1:0] {PM_CORE, PM_DRIVE, PM_HIGHZ} bsd_pinmode_e;

endpackage

// File: src/bsd_scan_port.sv
`timescale 1ns/1ps
module bsd_scan_port
    import bsd_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 clk_en,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdo_oe,
    input  wire logic [PINS-1:0]      pin_in,
    input  wire logic [PINS-1:0]      core_out,
    input  wire logic [PINS-1:0]      core_oe,
    input  wire logic [PINS-1:0]      bus_hold_en,
    output logic [PINS-1:0]           pin_out,
    output logic [PINS-1:0]           pin_oe,
    output logic [PINS-1:0]           pin_keep,
    output logic [IOSTD_LEN-1:0]      io_std,
    output logic [PLL_BITS-1:0]       pll_cfg,
    input  wire logic                 config_request_n,
    input  wire logic                 config_busy,
    input  wire logic                 config_done,
    output logic                      reconfig_start,
    output logic                      config_abort,
    output logic                      config_status_n
);

    // Test clock domain.

    bsd_tap_e              state;
    bsd_tap_e              next_state;
    logic [IR_LEN-1:0]     ir;
    logic [IR_LEN-1:0]     next_ir;
    logic [IR_LEN-1:0]     ir_shift;
    logic [IR_LEN-1:0]     next_ir_shift;
    logic                  byp;
    logic                  next_byp;
    logic [ID_LEN-1:0]     id_shift;
    logic [ID_LEN-1:0]     next_id_shift;
    logic [BSR_LEN-1:0]    bsr_shift;
    logic [BSR_LEN-1:0]    next_bsr_shift;
    logic [BSR_LEN-1:0]    bsr_upd;
    logic [BSR_LEN-1:0]    next_bsr_upd;
    logic [PLL_BITS-1:0]   pll_shift;
    logic [PLL_BITS-1:0]   next_pll_shift;
    logic [PLL_BITS-1:0]   pll_upd;
    logic [PLL_BITS-1:0]   next_pll_upd;
    logic [IOSTD_LEN-1:0]  iostd_shift;
    logic [IOSTD_LEN-1:0]  next_iostd_shift;
    logic [IOSTD_LEN-1:0]  iostd_upd;
    logic [IOSTD_LEN-1:0]  next_iostd_upd;
    bsd_pinmode_e          mode_t;
    bsd_pinmode_e          next_mode_t;
    logic                  upd_tgl;
    logic                  next_upd_tgl;
    logic                  pulse_tgl;
    logic                  next_pulse_tgl;
    logic                  cfgio_tgl;
    logic                  next_cfgio_tgl;
    logic                  next_tdo;
    logic                  next_tdo_oe;
    bsd_dr_e               dr_sel;

    logic [3*PINS:0]       t_sync1;
    logic [3*PINS:0]       t_sync2;
    logic [PINS-1:0]       pin_t;
    logic [PINS-1:0]       core_out_t;
    logic [PINS-1:0]       core_oe_t;
    logic                  done_t;

    assign pin_t      = t_sync2[PINS-1:0];
    assign core_out_t = t_sync2[2*PINS-1:PINS];
    assign core_oe_t  = t_sync2[3*PINS-1:2*PINS];
    assign done_t     = t_sync2[3*PINS];

    function automatic bsd_dr_e dr_of(input logic [IR_LEN-1:0] code);
        case (code)
            IR_SAMPLE, IR_EXTEST: dr_of = DR_BOUNDARY;
            IR_IDCODE:            dr_of = DR_IDCODE;
            IR_USERCODE:          dr_of = DR_USERCODE;
            IR_CONFIG_IO:         dr_of = DR_IOSTD;
            default:              dr_of = DR_BYPASS;
        endcase
    endfunction

    function automatic bsd_pinmode_e mode_of(input logic [IR_LEN-1:0] code);
        case (code)
            IR_EXTEST, IR_CLAMP: mode_of = PM_DRIVE;
            IR_HIGHZ:            mode_of = PM_HIGHZ;
            default:             mode_of = PM_CORE;
        endcase
    endfunction

    assign dr_sel = dr_of(ir);

    // Pins and core signals come from outside this domain and are only read after two stages.
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            t_sync1 <= '0;
            t_sync2 <= '0;
        end else begin
            t_sync1 <= {config_done, core_oe, core_out, pin_in};
            t_sync2 <= t_sync1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_RESET:  next_state = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  next_state = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  next_state = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    always_comb begin
        next_ir          = ir;
        next_ir_shift    = ir_shift;
        next_byp         = byp;
        next_id_shift    = id_shift;
        next_bsr_shift   = bsr_shift;
        next_bsr_upd     = bsr_upd;
        next_pll_shift   = pll_shift;
        next_pll_upd     = pll_upd;
        next_iostd_shift = iostd_shift;
        next_iostd_upd   = iostd_upd;
        next_mode_t      = mode_t;
        next_upd_tgl     = upd_tgl;
        next_pulse_tgl   = pulse_tgl;
        next_cfgio_tgl   = cfgio_tgl;
        case (state)
            ST_RESET: begin
                next_ir     = IR_IDCODE;
                next_mode_t = PM_CORE;
            end
            ST_CAP_IR: begin
                next_ir_shift = IR_CAPTURE;
            end
            ST_SH_IR: begin
                next_ir_shift = {tdi, ir_shift[IR_LEN-1:1]};
            end
            ST_UPD_IR: begin
                next_ir      = ir_shift;
                next_mode_t  = mode_of(ir_shift);
                next_upd_tgl = ~upd_tgl;
                if (ir_shift == IR_RECONFIG) begin
                    next_pulse_tgl = ~pulse_tgl;
                end
                if (ir_shift == IR_CONFIG_IO) begin
                    next_cfgio_tgl = ~cfgio_tgl;
                end
            end
            ST_CAP_DR: begin
                case (dr_sel)
                    DR_BYPASS:   next_byp = 1'b0;
                    DR_IDCODE:   next_id_shift = ID_VALUE;
                    DR_USERCODE: next_id_shift = USERCODE_VALUE;
                    DR_BOUNDARY: begin
                        for (int i = 0; i < PINS; i++) begin
                            next_bsr_shift[CELLS*i+CELL_IN]  = pin_t[i];
                            next_bsr_shift[CELLS*i+CELL_OUT] = core_out_t[i];
                            next_bsr_shift[CELLS*i+CELL_OE]  = core_oe_t[i];
                        end
                        next_pll_shift = pll_upd;
                    end
                    DR_IOSTD:    next_iostd_shift = iostd_upd;
                    default:     next_byp = 1'b0;
                endcase
            end
            ST_SH_DR: begin
                case (dr_sel)
                    DR_BYPASS:   next_byp = tdi;
                    DR_IDCODE,
                    DR_USERCODE: next_id_shift = {tdi, id_shift[ID_LEN-1:1]};
                    DR_BOUNDARY: begin
                        if (!done_t) begin
                            // The PLL bits lead the chain until configuration completes.
                            next_pll_shift = {tdi, pll_shift[PLL_BITS-1:1]};
                            next_bsr_shift = {pll_shift[0], bsr_shift[BSR_LEN-1:1]};
                        end else begin
                            next_bsr_shift = {tdi, bsr_shift[BSR_LEN-1:1]};
                        end
                    end
                    DR_IOSTD:    next_iostd_shift = {tdi, iostd_shift[IOSTD_LEN-1:1]};
                    default:     next_byp = tdi;
                endcase
            end
            ST_UPD_DR: begin
                next_upd_tgl = ~upd_tgl;
                if (dr_sel == DR_BOUNDARY) begin
                    next_bsr_upd = bsr_shift;
                    if (!done_t) begin
                        next_pll_upd = pll_shift;
                    end
                end
                if (dr_sel == DR_IOSTD) begin
                    next_iostd_upd = iostd_shift;
                end
            end
            default: begin
                next_ir = ir;
            end
        endcase
        // Core mode is set on the same edge as the toggle, since a slow test clock may not tick again in time.
        if (next_state == ST_RESET && state != ST_RESET) begin
            next_upd_tgl = ~next_upd_tgl;
            next_mode_t  = PM_CORE;
        end
    end

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            state       <= ST_RESET;
            ir          <= IR_IDCODE;
            ir_shift    <= '0;
            byp         <= 1'b0;
            id_shift    <= '0;
            bsr_shift   <= '0;
            bsr_upd     <= '0;
            pll_shift   <= '0;
            pll_upd     <= '0;
            iostd_shift <= '0;
            iostd_upd   <= '0;
            mode_t      <= PM_CORE;
            upd_tgl     <= 1'b0;
            pulse_tgl   <= 1'b0;
            cfgio_tgl   <= 1'b0;
        end else begin
            state       <= next_state;
            ir          <= next_ir;
            ir_shift    <= next_ir_shift;
            byp         <= next_byp;
            id_shift    <= next_id_shift;
            bsr_shift   <= next_bsr_shift;
            bsr_upd     <= next_bsr_upd;
            pll_shift   <= next_pll_shift;
            pll_upd     <= next_pll_upd;
            iostd_shift <= next_iostd_shift;
            iostd_upd   <= next_iostd_upd;
            mode_t      <= next_mode_t;
            upd_tgl     <= next_upd_tgl;
            pulse_tgl   <= next_pulse_tgl;
            cfgio_tgl   <= next_cfgio_tgl;
        end
    end

    // Serial output changes on the falling edge so the tester samples it stable.
    always_comb begin
        next_tdo    = 1'b0;
        next_tdo_oe = 1'b0;
        if (state == ST_SH_IR) begin
            next_tdo    = ir_shift[0];
            next_tdo_oe = 1'b1;
        end else if (state == ST_SH_DR) begin
            next_tdo_oe = 1'b1;
            case (dr_sel)
                DR_IDCODE, DR_USERCODE: next_tdo = id_shift[0];
                DR_BOUNDARY:            next_tdo = bsr_shift[0];
                DR_IOSTD:               next_tdo = iostd_shift[0];
                default:                next_tdo = byp;
            endcase
        end
    end

    always_ff @(negedge tck or negedge arst_n) begin
        if (!arst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= next_tdo;
            tdo_oe <= next_tdo_oe;
        end
    end

    // System clock domain.

    logic [3:0]            s_sync1;
    logic [3:0]            s_sync2;
    logic [3:0]            s_prev;
    logic                  done_prev;
    logic                  upd_ev;
    logic                  pulse_ev;
    logic                  cfgio_ev;
    logic                  req_fall;
    logic                  cfgio_hold;
    logic                  next_cfgio_hold;
    bsd_pinmode_e          mode_s;
    bsd_pinmode_e          next_mode_s;
    logic [BSR_LEN-1:0]    bsr_s;
    logic [BSR_LEN-1:0]    next_bsr_s;
    logic [PINS-1:0]       next_pin_out;
    logic [PINS-1:0]       next_pin_oe;
    logic [PINS-1:0]       next_pin_keep;
    logic [IOSTD_LEN-1:0]  next_io_std;
    logic [PLL_BITS-1:0]   next_pll_cfg;
    logic                  next_reconfig_start;
    logic                  next_config_abort;

    // Toggles cross as levels; the words they announce are held still in the test domain.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_sync1 <= 4'h1;
            s_sync2 <= 4'h1;
        end else if (clk_en) begin
            s_sync1 <= {cfgio_tgl, pulse_tgl, upd_tgl, config_request_n};
            s_sync2 <= s_sync1;
        end
    end

    assign req_fall = s_prev[0] & ~s_sync2[0];
    assign upd_ev   = s_prev[1] ^ s_sync2[1];
    assign pulse_ev = s_prev[2] ^ s_sync2[2];
    assign cfgio_ev = s_prev[3] ^ s_sync2[3];

    always_comb begin
        next_mode_s  = mode_s;
        next_bsr_s   = bsr_s;
        next_io_std  = io_std;
        next_pll_cfg = pll_cfg;
        if (upd_ev) begin
            next_mode_s  = mode_t;
            next_bsr_s   = bsr_upd;
            next_io_std  = iostd_upd;
            next_pll_cfg = pll_upd;
        end
        for (int i = 0; i < PINS; i++) begin
            case (next_mode_s)
                PM_DRIVE: begin
                    next_pin_out[i] = next_bsr_s[CELLS*i+CELL_OUT];
                    next_pin_oe[i]  = next_bsr_s[CELLS*i+CELL_OE];
                end
                PM_HIGHZ: begin
                    next_pin_out[i] = 1'b0;
                    next_pin_oe[i]  = 1'b0;
                end
                default: begin
                    next_pin_out[i] = core_out[i];
                    next_pin_oe[i]  = core_oe[i];
                end
            endcase
            next_pin_keep[i] = (next_mode_s != PM_CORE) & ~next_pin_oe[i] & bus_hold_en[i];
        end
        next_reconfig_start = req_fall | pulse_ev;
        next_config_abort   = cfgio_ev & config_busy;
        // A new issue wins over a completion seen in the same cycle.
        next_cfgio_hold = cfgio_hold;
        if (config_done && !done_prev) begin
            next_cfgio_hold = 1'b0;
        end
        if (cfgio_ev) begin
            next_cfgio_hold = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_prev          <= 4'h1;
            done_prev       <= 1'b0;
            mode_s          <= PM_CORE;
            bsr_s           <= '0;
            io_std          <= '0;
            pll_cfg         <= '0;
            pin_out         <= '0;
            pin_oe          <= '0;
            pin_keep        <= '0;
            reconfig_start  <= 1'b0;
            config_abort    <= 1'b0;
            cfgio_hold      <= 1'b0;
            config_status_n <= 1'b1;
        end else if (clk_en) begin
            s_prev          <= s_sync2;
            done_prev       <= config_done;
            mode_s          <= next_mode_s;
            bsr_s           <= next_bsr_s;
            io_std          <= next_io_std;
            pll_cfg         <= next_pll_cfg;
            pin_out         <= next_pin_out;
            pin_oe          <= next_pin_oe;
            pin_keep        <= next_pin_keep;
            reconfig_start  <= next_reconfig_start;
            config_abort    <= next_config_abort;
            cfgio_hold      <= next_cfgio_hold;
            config_status_n <= ~next_cfgio_hold;
        end
    end

endmodule

// File: sim/bsd_checker.sv
`timescale 1ns/1ps
module bsd_checker
    import bsd_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                arst_n,
    input wire logic                tck,
    input wire logic                tdo,
    input wire logic                tdo_oe,
    input wire logic [PINS-1:0]     bus_hold_en,
    input wire logic [PINS-1:0]     pin_oe,
    input wire logic [PINS-1:0]     pin_keep,
    input wire logic [PLL_BITS-1:0] pll_cfg,
    input wire logic                config_request_n,
    input wire logic                config_busy,
    input wire logic                config_done,
    input wire logic                reconfig_start,
    input wire logic                config_abort,
    input wire logic                config_status_n
);
    start_single_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reconfig_start |=> !reconfig_start)
        else $error("reconfig_start held longer than one cycle");
    request_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(config_request_n) |-> ##[2:4] reconfig_start)
        else $error("no reconfig_start after config_request_n fell");
    abort_cause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        config_abort |-> $past(config_busy) ##1 !config_abort)
        else $error("config_abort without busy or too long");
    abort_status_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        config_abort |-> !config_status_n)
        else $error("config_abort without config_status_n low");
    status_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !config_status_n && !config_done |=> !config_status_n)
        else $error("config_status_n released before reconfiguration");
    status_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(config_status_n) |-> $past(config_done))
        else $error("config_status_n released without config_done");
    keeper_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (pin_keep & (pin_oe | ~bus_hold_en)) == '0)
        else $error("keeper active on a driven or disabled pin");
    pll_frozen_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        config_done && $past(config_done, 8) |-> $stable(pll_cfg))
        else $error("pll_cfg changed after configuration");
    // The serial output belongs to the test clock, so it is judged on that clock.
    tdo_quiet_a: assert property (@(posedge tck) disable iff (!arst_n)
        !tdo_oe |-> !tdo)
        else $error("tdo high outside shift");
endmodule

// File: sim/bsd_tester.sv
`timescale 1ns/1ps
module bsd_tester
    import bsd_pkg::*;
(
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // The cable clock stands still between frames; tdi idles at its pull-up level.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    task automatic tick(input logic m, input logic dv, output logic q);
        tms = m;
        tdi = dv;
        #3;
        tck = 1'b1;
        q = tdo;
        #3;
        tck = 1'b0;
    endtask

    task automatic reset_tap();
        logic q;
        repeat (5) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask

    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b1, q);
        if (ir) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        tick(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        tdi = 1'b1;
    endtask

    task automatic load_ir(input logic [IR_LEN-1:0] code);
        logic [31:0] dout;
        scan(1'b1, IR_LEN, {22'h00_0000, code}, dout);
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import bsd_pkg::*;
    logic                 sys_clk, arst_n, clk_en, tck, tms, tdi, tdo, tdo_oe;
    logic [PINS-1:0]      pin_in, core_out, core_oe, bus_hold_en, pin_out, pin_oe, pin_keep;
    logic [IOSTD_LEN-1:0] io_std;
    logic [PLL_BITS-1:0]  pll_cfg;
    logic                 config_request_n, config_busy, config_done, reconfig_start, config_abort, config_status_n;
    logic [31:0]          d;
    int                   errors = 0, n_tests = 0, n_start = 0, n_abort = 0;

    bsd_scan_port dut (.sys_clk, .arst_n, .clk_en, .tck, .tms, .tdi, .tdo, .tdo_oe, .pin_in, .core_out,
                       .core_oe, .bus_hold_en, .pin_out, .pin_oe, .pin_keep, .io_std, .pll_cfg,
                       .config_request_n, .config_busy, .config_done, .reconfig_start, .config_abort,
                       .config_status_n);
    bsd_tester tester (.tck, .tms, .tdi, .tdo);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (reconfig_start === 1'b1) n_start <= n_start + 1;
        if (config_abort === 1'b1) n_abort <= n_abort + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sys_wait(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Updates cross by toggle, so each one is given six system cycles before the next.
    task automatic ir(input logic [IR_LEN-1:0] code);
        tester.load_ir(code);
        sys_wait(6);
    endtask

    task automatic dr(input int n, input logic [31:0] din);
        tester.scan(1'b0, n, din, d);
        sys_wait(6);
    endtask

    function automatic logic [BSR_LEN-1:0] bsr_word(input logic [PINS-1:0] i, o, e);
        for (int k = 0; k < PINS; k++) begin
            bsr_word[CELLS*k+CELL_IN]  = i[k];
            bsr_word[CELLS*k+CELL_OUT] = o[k];
            bsr_word[CELLS*k+CELL_OE]  = e[k];
        end
    endfunction

    task automatic t_ident();
        tester.reset_tap();
        dr(ID_LEN, 32'h0000_0000);
        check(d, ID_VALUE);
        ir(IR_USERCODE);
        dr(ID_LEN, 32'hFFFF_FFFF);
        check(d, USERCODE_VALUE);
    endtask

    task automatic t_pll();
        ir(IR_SAMPLE);
        dr(16, 32'h0000_A000);
        check(32'(d[15:12]), 32'h0000_0000);
        check(32'(d[11:0]), 32'(bsr_word(pin_in, core_out, core_oe)));
        check(32'(pll_cfg), 32'h0000_000A);
    endtask

    task automatic t_extest();
        ir(IR_SAMPLE);
        dr(16, {16'h0000, bsr_word(4'h0, 4'h9, 4'hF), 4'h3});
        check(32'(d[15:12]), 32'h0000_0003);
        check(32'(d[11:0]), 32'(bsr_word(pin_in, core_out, core_oe)));
        check(32'({pll_cfg, pin_out}), 32'h0000_00A6);
        ir(IR_EXTEST);
        check(32'({pin_out, pin_oe}), 32'h0000_009F);
        dr(BSR_LEN, 32'(bsr_word(4'h0, 4'h9, 4'hF)));
        check(32'(d[11:0]), 32'(bsr_word(pin_in, core_out, core_oe)));
        tester.reset_tap();
        sys_wait(6);
        check(32'({pin_out, pin_oe}), 32'h0000_006C);
    endtask

    task automatic t_bypass();
        logic [IR_LEN-1:0] code [4] = '{IR_CLAMP, IR_HIGHZ, IR_BYPASS, 10'h2C4};
        logic [PINS-1:0]   oe [4]   = '{4'hF, 4'h0, 4'hC, 4'hC};
        logic [PINS-1:0]   ot [4]   = '{4'h9, 4'h0, 4'h6, 4'h6};
        logic [PINS-1:0]   kp [4]   = '{4'h0, 4'h5, 4'h0, 4'h0};
        int                s;
        s = n_start;
        for (int k = 0; k < 4; k++) begin
            ir(code[k]);
            dr(9, 32'h0000_00A5);
            check(32'(d[8:0]), 32'h0000_014A);
            check(32'({pin_oe, pin_out & oe[k]}), 32'({oe[k], ot[k] & oe[k]}));
            check(32'(pin_keep), 32'(kp[k]));
        end
        check(32'(n_start - s), 32'h0000_0000);
    endtask

    task automatic t_reconfig();
        int s;
        s = n_start;
        ir(IR_RECONFIG);
        check(32'(n_start - s), 32'h0000_0001);
        config_request_n = 1'b0;
        sys_wait(2);
        config_request_n = 1'b1;
        sys_wait(6);
        check(32'(n_start - s), 32'h0000_0002);
    endtask

    task automatic t_config_io();
        config_done = 1'b0;
        config_busy = 1'b1;
        sys_wait(2);
        ir(IR_CONFIG_IO);
        check(32'({n_abort, config_status_n}), 32'h0000_0002);
        dr(IOSTD_LEN, 32'h0000_006C);
        check(32'(io_std), 32'h0000_006C);
        config_busy = 1'b0;
        sys_wait(10);
        check(32'(config_status_n), 32'h0000_0000);
        config_done = 1'b1;
        sys_wait(8);
        check(32'(config_status_n), 32'h0000_0001);
        ir(IR_CONFIG_IO);
        check(32'({n_abort, config_status_n}), 32'h0000_0002);
    endtask

    task automatic print_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        {arst_n, config_busy, config_done} = 3'h0;
        {clk_en, config_request_n} = 2'h3;
        {pin_in, core_out, core_oe, bus_hold_en} = 16'hA6C5;
        sys_wait(20);
        arst_n = 1'b1;
        sys_wait(2);
        t_ident();
        t_pll();
        config_done = 1'b1; // later boundary tests run only once configuration has finished
        sys_wait(8);
        t_extest();
        t_bypass();
        t_reconfig();
        t_config_io();
        print_verdict();
    end

    initial begin
        #2_000_000;
        errors++;
        print_verdict();
    end
endmodule

bind bsd_scan_port bsd_checker chk (.sys_clk, .arst_n, .tck, .tdo, .tdo_oe, .bus_hold_en, .pin_oe, .pin_keep,
                                    .config_request_n, .config_busy, .config_done, .reconfig_start, .config_abort,
                                    .pll_cfg, .config_status_n);
